// File: hw/pei_top.sv
/*
 * PHY event interrupt control, masked event status with clear-on-read
 * pending flag, two saturating 8-bit error counters and the 100 Mb/s PCS
 * configuration bits.
 * Assumes all event inputs are single-cycle pulses or levels produced by
 * logic on i_ref_clk, and a simple register port: one-cycle read or write
 * strobes with address and data, read data returned one cycle later.
 */
// Function
// - Link change, jabber, remote fault, autoneg done, counter half-full are events.
// - Test interrupt works regardless of the event interrupt enable.
// - Control bit 0 set raises an interrupt at every register read completion.
// - Control bit 1 gates event interrupts; zero suppresses all of them.
// - Event interrupts only when its mask bit clear and enable set.
// - Status bit 15 reads pending, read-only, cleared by the read returning it.
// - Mask bits 14..9 map link, jabber, fault, autoneg, carrier half, error half.
// - Reserved bits ignore writes and read as zero.
// - False carrier counter counts each event and saturates at FFh.
// - False carrier counter resets to zero, is writable, clears on read.
// - Error counter counts once per carrier, needs invalid symbol, no collision.
// - Error counter saturates, resets to zero, is writable, clears on read.
// - PCS bit 12 set bypasses the 4B/5B encoder functions.
// - PCS bit 11 set makes the receive clock free-running.
// - PCS bit 10 set selects the true quiet transmit mode.
// - PCS bit 9 set forces the signal detect indication active.
// - PCS bit 8 selects enhanced signal detect; reset value 0100h.
// - PCS bit 5 forces good 100 Mb/s link, ORed with controller override.
// - PCS bit 2 set bypasses NRZI encoding and decoding.
// - All registers 16 bits; reset 0000h except PCS config at 0100h.
`include "pei_regs.svh"
module pei_top (
    input  wire logic        i_ref_clk,                  // Core clock, 200 MHz
    input  wire logic        i_reset,                    // Synchronous reset, high
    // Register port
    input  wire logic        i_reg_rd,                   // Read strobe, one cycle
    input  wire logic        i_reg_wr,                   // Write strobe, one cycle
    input  wire logic [7:0]  i_reg_addr,                 // Byte offset
    input  wire logic [15:0] i_reg_wdata,                // Write data
    output logic [15:0]      o_reg_rdata,                // Read data, registered
    output logic             o_reg_rvalid,               // Read data valid pulse
    // Events from the PHY logic
    input  wire logic        i_link_change,              // Link state change pulse
    input  wire logic        i_jabber,                   // Jabber event pulse
    input  wire logic        i_remote_fault,             // Remote fault pulse
    input  wire logic        i_autoneg_done,             // Autoneg complete pulse
    input  wire logic        i_false_carrier,            // False carrier event pulse
    input  wire logic        i_carrier_valid,            // Valid carrier level
    input  wire logic        i_invalid_symbol,           // Invalid data symbol pulse
    input  wire logic        i_collision,                // Collision level
    input  wire logic        i_controller_fast_link_override, // Controller force link
    // Interrupt and PCS controls
    output logic             o_host_status_phy_flag,     // PHY interrupt pending
    output logic             o_block_code_skip,          // Bypass 4B/5B
    output logic             o_receive_clock_free_run,   // Free-running rx clock
    output logic             o_true_quiet_transmit_select, // True quiet transmit
    output logic             o_signal_detect_override,   // Force signal detect
    output logic             o_signal_detect_algorithm_select, // 1 = enhanced
    output logic             o_fast_link_force,          // Forced good 100 link
    output logic             o_nrzi_skip                 // Bypass NRZI
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Saturating increment; holding at the top keeps the tally honest
    function automatic logic [7:0] pei_sat_inc(input logic [7:0] value);
        logic [7:0] result;
        result = value;
        if (value != `PEI_CNT_MAX) begin
            result = value + 8'h01;
        end
        return result;
    endfunction : pei_sat_inc

    // Top bit rising from one value to the next
    function automatic logic pei_half_rise(input logic [7:0] old_val,
                                           input logic [7:0] new_val);
        return !old_val[`PEI_CNT_HI] && new_val[`PEI_CNT_HI];
    endfunction : pei_half_rise

    // Address match helper, shared by read and write decode
    function automatic logic pei_hit(input logic [7:0] addr,
                                     input logic [7:0] offset);
        return addr == offset;
    endfunction : pei_hit

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------

    pei_pkg::pei_state_type state_reg;
    pei_pkg::pei_state_type state_next;

    // Decoded accesses and derived events
    logic                   hit_ctrl;
    logic                   hit_stat;
    logic                   hit_fc;
    logic                   hit_se;
    logic                   hit_pcs;
    logic                   se_event;
    pei_pkg::pei_event_type events;

    // Address decode, reused by both strobes
    always_comb begin
        hit_ctrl = pei_hit(i_reg_addr, `PEI_OFF_IRQ_CTRL);
        hit_stat = pei_hit(i_reg_addr, `PEI_OFF_IRQ_STAT_MASK);
        hit_fc   = pei_hit(i_reg_addr, `PEI_OFF_FALSE_CARRIER);
        hit_se   = pei_hit(i_reg_addr, `PEI_OFF_SYMBOL_ERROR);
        hit_pcs  = pei_hit(i_reg_addr, `PEI_OFF_PCS_CONFIG);
    end

    // Qualified symbol error: once per carrier, never during a collision
    assign se_event = i_carrier_valid && i_invalid_symbol
                      && !i_collision && !state_reg.se_seen;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    always_comb begin
        logic [7:0] fc_base;
        logic [7:0] se_base;
        logic       test_set;
        logic       event_set;
        fc_base    = 8'h00;
        se_base    = 8'h00;
        test_set   = 1'b0;
        event_set  = 1'b0;
        state_next = state_reg;
        events     = '0;

        // Read data; unmapped offsets and reserved bits return zero
        state_next.rvalid = i_reg_rd;
        state_next.rdata  = `PEI_RST_ZERO;
        if (i_reg_rd) begin
            if (hit_ctrl) begin
                state_next.rdata[`PEI_CTRL_TEST_BIT]  = state_reg.test_force;
                state_next.rdata[`PEI_CTRL_ALLOW_BIT] = state_reg.event_allow;
            end
            if (hit_stat) begin
                state_next.rdata[`PEI_STAT_PENDING_BIT] = state_reg.pending;
                state_next.rdata[`PEI_STAT_MASK_HI:`PEI_STAT_MASK_LO] = state_reg.mask;
            end
            if (hit_fc) begin
                state_next.rdata[`PEI_CNT_HI:0] = state_reg.fc_count;
            end
            if (hit_se) begin
                state_next.rdata[`PEI_CNT_HI:0] = state_reg.se_count;
            end
            if (hit_pcs) begin
                state_next.rdata = state_reg.pcs;
            end
        end

        // Control and mask writes; read-only and reserved bits dropped
        if (i_reg_wr && hit_ctrl) begin
            state_next.test_force  = i_reg_wdata[`PEI_CTRL_TEST_BIT];
            state_next.event_allow = i_reg_wdata[`PEI_CTRL_ALLOW_BIT];
        end
        if (i_reg_wr && hit_stat) begin
            state_next.mask = i_reg_wdata[`PEI_STAT_MASK_HI:`PEI_STAT_MASK_LO];
        end
        if (i_reg_wr && hit_pcs) begin
            state_next.pcs = i_reg_wdata & `PEI_PCS_WRITE_MASK;
        end

        // False carrier tally: clear on read, else write, then count
        if (i_reg_rd && hit_fc) begin
            fc_base = 8'h00;
        end else if (i_reg_wr && hit_fc) begin
            fc_base = i_reg_wdata[`PEI_CNT_HI:0];
        end else begin
            fc_base = state_reg.fc_count;
        end
        // Counting after the clear keeps an event landing on the read
        state_next.fc_count = i_false_carrier ? pei_sat_inc(fc_base) : fc_base;

        // Symbol error tally, same precedence as the carrier tally
        if (i_reg_rd && hit_se) begin
            se_base = 8'h00;
        end else if (i_reg_wr && hit_se) begin
            se_base = i_reg_wdata[`PEI_CNT_HI:0];
        end else begin
            se_base = state_reg.se_count;
        end
        state_next.se_count = se_event ? pei_sat_inc(se_base) : se_base;

        // One count per carrier: arm when carrier ends
        if (!i_carrier_valid) begin
            state_next.se_seen = 1'b0;
        end else if (se_event) begin
            state_next.se_seen = 1'b1;
        end

        // Event vector in mask bit order, 14 down to 9
        events[5] = i_link_change;
        events[4] = i_jabber;
        events[3] = i_remote_fault;
        events[2] = i_autoneg_done;
        events[1] = pei_half_rise(state_reg.fc_count, state_next.fc_count);
        events[0] = pei_half_rise(state_reg.se_count, state_next.se_count);

        // Masked, enabled events; enable off blocks every event source
        event_set = state_reg.event_allow && |(events & ~state_reg.mask);

        // Test interrupt on every read, independent of the enable
        test_set = i_reg_rd && state_reg.test_force;

        // Pending: read clears it, but a same-cycle set wins
        if (i_reg_rd && hit_stat) begin
            state_next.pending = 1'b0;
        end
        if (event_set || test_set) begin
            state_next.pending = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Hard reset values; only the PCS register is not all zero
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_reg             <= '0;
            state_reg.pcs         <= `PEI_RST_PCS_CONFIG;
            state_reg.rdata       <= `PEI_RST_ZERO;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Register port answer
    assign o_reg_rdata  = state_reg.rdata;
    assign o_reg_rvalid = state_reg.rvalid;

    // Interrupt towards the host status register
    assign o_host_status_phy_flag = state_reg.pending;

    // PCS controls straight from the register bits
    assign o_block_code_skip               = state_reg.pcs[`PEI_PCS_BLOCK_SKIP];
    assign o_receive_clock_free_run        = state_reg.pcs[`PEI_PCS_FREE_CLK];
    assign o_true_quiet_transmit_select    = state_reg.pcs[`PEI_PCS_TRUE_QUIET];
    assign o_signal_detect_override        = state_reg.pcs[`PEI_PCS_SD_OVERRIDE];
    assign o_signal_detect_algorithm_select = state_reg.pcs[`PEI_PCS_SD_ALGO];
    assign o_nrzi_skip                     = state_reg.pcs[`PEI_PCS_NRZI_SKIP];

    // The controller override is a live input, so the OR is combinational
    assign o_fast_link_force = state_reg.pcs[`PEI_PCS_FORCE_LINK]
                               || i_controller_fast_link_override;

endmodule : pei_top

// File: hw/pei_regs.svh
/*
 * Offsets, reset values, field positions and widths of the PHY event,
 * interrupt and counter registers.
 * Assumes the includer uses these names only; definitions only here.
 */
`ifndef PEI_REGS_SVH
`define PEI_REGS_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses in the controller space)
// ----------------------------------------------------------------------
`define PEI_OFF_IRQ_CTRL      8'hc4
`define PEI_OFF_IRQ_STAT_MASK 8'hc8
`define PEI_OFF_FALSE_CARRIER 8'hd0
`define PEI_OFF_SYMBOL_ERROR  8'hd4
`define PEI_OFF_PCS_CONFIG    8'hd8
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PEI_RST_ZERO          16'h0000
`define PEI_RST_PCS_CONFIG    16'h0100
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PEI_CTRL_TEST_BIT     0
`define PEI_CTRL_ALLOW_BIT    1
`define PEI_STAT_PENDING_BIT  15
`define PEI_STAT_MASK_HI      14
`define PEI_STAT_MASK_LO      9
`define PEI_CNT_HI            7
`define PEI_PCS_BLOCK_SKIP    12
`define PEI_PCS_FREE_CLK      11
`define PEI_PCS_TRUE_QUIET    10
`define PEI_PCS_SD_OVERRIDE   9
`define PEI_PCS_SD_ALGO       8
`define PEI_PCS_FORCE_LINK    5
`define PEI_PCS_NRZI_SKIP     2
// Writable bits of the PCS configuration register
`define PEI_PCS_WRITE_MASK    16'h1f24
// ----------------------------------------------------------------------
// Widths and limits
// ----------------------------------------------------------------------
`define PEI_CNT_MAX           8'hff
`define PEI_ADDR_W            8
`define PEI_DATA_W            16
`endif

// File: hw/pei_pkg.sv
/*
 * Types of the PHY event, interrupt and counter register block.
 * Assumes pei_regs.svh is on the include path.
 */
`include "pei_regs.svh"
package pei_pkg;
    // Event vector order matches mask bits 14 down to 9
    typedef logic [5:0] pei_event_type;

    // Whole state of the block
    typedef struct packed {
        logic          test_force;   // Test interrupt control
        logic          event_allow;  // Event interrupt enable
        pei_event_type mask;         // Event blocks, 1 = blocked
        logic          pending;      // Interrupt pending flag
        logic [7:0]    fc_count;     // False carrier tally
        logic [7:0]    se_count;     // Symbol error tally
        logic          se_seen;      // Error already counted in carrier
        logic [15:0]   pcs;          // PCS configuration bits
        logic [15:0]   rdata;        // Read data
        logic          rvalid;       // Read data valid
    } pei_state_type;
endpackage : pei_pkg

// File: verification/pei_top_monitor.sv
/*
 * Concurrent checks on the ports of the PHY event register block.
 * Assumes one clock, synchronous active-high reset, bound to pei_top.
 */
// ----------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------
module pei_top_monitor (
    input  wire logic        i_ref_clk,                        // Core clock
    input  wire logic        i_reset,                          // Sync reset
    input  wire logic        i_reg_rd,                         // Read strobe
    input  wire logic        i_reg_wr,                         // Write strobe
    input  wire logic [7:0]  i_reg_addr,                       // Offset
    input  wire logic [15:0] i_reg_wdata,                      // Write data
    input  wire logic [15:0] o_reg_rdata,                      // Read data
    input  wire logic        o_reg_rvalid,                     // Read valid
    input  wire logic        i_controller_fast_link_override,  // Link override
    input  wire logic        o_host_status_phy_flag,           // Pending flag
    input  wire logic        o_fast_link_force,                // Forced link
    input  wire logic        o_signal_detect_algorithm_select  // Detect option
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shadow of allow and test bits, since the checker cannot see state
    logic [1:0] ctl_reg;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) ctl_reg <= 2'h0;
        else if (i_reg_wr && i_reg_addr == 8'hc4) ctl_reg <= i_reg_wdata[1:0];
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    sequence s_rd(a); i_reg_rd && i_reg_addr == a; endsequence
    sequence s_quiet; !ctl_reg[1] && !ctl_reg[0]; endsequence
    chk_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    chk_idle_zero: assert property (!o_reg_rvalid |-> o_reg_rdata == 16'h0)
        else $error("read data not zero when idle");
    chk_test_set: assert property (i_reg_rd && ctl_reg[0] |=> o_host_status_phy_flag)
        else $error("test interrupt missing");
    chk_no_event: assert property (s_quiet ##0 !o_host_status_phy_flag |=> !o_host_status_phy_flag)
        else $error("flag rose while disabled");
    chk_flag_hold: assert property (o_host_status_phy_flag && !i_reg_rd |=> o_host_status_phy_flag)
        else $error("flag dropped without read");
    chk_read_clear: assert property (s_rd(8'hc8) ##0 s_quiet ##0 o_host_status_phy_flag
        |=> !o_host_status_phy_flag)
        else $error("status read did not clear flag");
    chk_ctrl_rsvd: assert property (s_rd(8'hc4) |=> o_reg_rdata == {14'h0, ctl_reg})
        else $error("control readback wrong");
    chk_stat_rsvd: assert property (s_rd(8'hc8) |=> o_reg_rdata[8:0] == 9'h0)
        else $error("status low bits not zero");
    chk_count_rsvd: assert property (i_reg_rd && i_reg_addr[7:4] == 4'hd && !i_reg_addr[3]
        |=> o_reg_rdata[15:8] == 8'h0)
        else $error("counter high bits not zero");
    chk_link_or: assert property (i_controller_fast_link_override |-> o_fast_link_force)
        else $error("link override not passed");
    chk_algo_reset: assert property ($fell(i_reset) |-> o_signal_detect_algorithm_select)
        else $error("detect option reset wrong");
endmodule : pei_top_monitor

bind pei_top pei_top_monitor u_mon (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reg_rd(i_reg_rd),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_controller_fast_link_override(i_controller_fast_link_override),
    .o_host_status_phy_flag(o_host_status_phy_flag), .o_fast_link_force(o_fast_link_force),
    .o_signal_detect_algorithm_select(o_signal_detect_algorithm_select));

// File: verification/tb.sv
/*
 * Self-checking bench for pei_top with a cycle model compared every cycle.
 * Assumes the register port contract: one-cycle strobes, data one cycle later.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk, i_reset, i_reg_rd, i_reg_wr, o_reg_rvalid, o_host_status_phy_flag, o_fast_link_force;
    logic [7:0]  i_reg_addr;
    logic [15:0] i_reg_wdata, o_reg_rdata, m_pcs, m_rd;
    logic [8:0]  ev;      // link jab fault aneg fc cv sym col override
    wire  [5:0]  pcs_o;   // Skip, free clock, quiet, override, option, nrzi
    logic [5:0]  m_mask;
    logic        m_test, m_allow, m_pend, m_seen, m_rv;
    int          m_fc, m_se, n_errors = 0, n_checks = 0, seed = 6, r;
    logic [7:0]  addrs [6] = '{8'hc4, 8'hc8, 8'hd0, 8'hd4, 8'hd8, 8'hcc};
    pei_top uut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_link_change(ev[8]), .i_jabber(ev[7]), .i_remote_fault(ev[6]), .i_autoneg_done(ev[5]),
        .i_false_carrier(ev[4]), .i_carrier_valid(ev[3]), .i_invalid_symbol(ev[2]), .i_collision(ev[1]),
        .i_controller_fast_link_override(ev[0]), .o_host_status_phy_flag(o_host_status_phy_flag),
        .o_block_code_skip(pcs_o[5]), .o_receive_clock_free_run(pcs_o[4]), .o_true_quiet_transmit_select(pcs_o[3]),
        .o_signal_detect_override(pcs_o[2]), .o_signal_detect_algorithm_select(pcs_o[1]),
        .o_fast_link_force(o_fast_link_force), .o_nrzi_skip(pcs_o[0]));
    // ------------------------------------------------------------------
    // Clock and reference model, updated on the same edge as the design
    // ------------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        int fc, se;
        logic inc;
        if (i_reset) begin
            {m_test, m_allow, m_mask, m_pend, m_seen, m_rv, m_rd} = '0;
            m_fc = 0; m_se = 0; m_pcs = 16'h0100;
        end else begin
            m_rv = i_reg_rd;
            case (i_reg_addr)
                8'hc4: m_rd = {14'h0, m_allow, m_test};
                8'hc8: m_rd = {m_pend, m_mask, 9'h0};
                8'hd0: m_rd = 16'(m_fc);
                8'hd4: m_rd = 16'(m_se);
                8'hd8: m_rd = m_pcs;
                default: m_rd = 16'h0;
            endcase
            if (!i_reg_rd) m_rd = 16'h0;
            // Read clears first, a write loads, then the increment lands on top
            fc = (i_reg_rd && i_reg_addr == 8'hd0) ? 0 : (i_reg_wr && i_reg_addr == 8'hd0) ? i_reg_wdata[7:0] : m_fc;
            se = (i_reg_rd && i_reg_addr == 8'hd4) ? 0 : (i_reg_wr && i_reg_addr == 8'hd4) ? i_reg_wdata[7:0] : m_se;
            inc = ev[3] && ev[2] && !ev[1] && !m_seen;
            if (ev[4] && fc < 255) fc++;
            if (inc && se < 255) se++;
            m_pend = (m_pend && !(i_reg_rd && i_reg_addr == 8'hc8)) || (i_reg_rd && m_test) ||
                     (m_allow && ({ev[8:5], m_fc < 128 && fc > 127, m_se < 128 && se > 127} & ~m_mask) != 0);
            m_seen = ev[3] && (m_seen || inc);
            m_fc = fc; m_se = se;
            if (i_reg_wr && i_reg_addr == 8'hc4) {m_allow, m_test} = i_reg_wdata[1:0];
            if (i_reg_wr && i_reg_addr == 8'hc8) m_mask = i_reg_wdata[14:9];
            if (i_reg_wr && i_reg_addr == 8'hd8) m_pcs = i_reg_wdata & 16'h1f24;
        end
    end
    // ------------------------------------------------------------------
    // Compare, drive one cycle at the falling edge, close the run
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Outputs are checked before the inputs move, so nothing races the model
    task automatic tick(input logic rd, input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [8:0] e);
        check(o_reg_rdata, m_rd);
        check({o_reg_rvalid, o_host_status_phy_flag}, {m_rv, m_pend});
        check({pcs_o, o_fast_link_force}, {m_pcs[12:8], m_pcs[2], m_pcs[5] | ev[0]});
        {i_reg_rd, i_reg_wr, i_reg_addr, i_reg_wdata, ev} = {rd, wr, a, d, e};
        @(negedge i_ref_clk);
    endtask : tick
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        {i_reset, i_reg_rd, i_reg_wr, i_reg_addr, i_reg_wdata, ev} = {1'b1, 35'h0};
        repeat (6) @(negedge i_ref_clk);
        i_reset = 1'b0;
        // Reset values, then all-ones writes read back through reserved bits
        foreach (addrs[k]) tick(1, 0, addrs[k], 0, 0);
        foreach (addrs[k]) begin
            tick(0, 1, addrs[k], 16'hffff, 0);
            tick(1, 0, addrs[k], 0, 0);
        end
        // Each direct event alone with only its own block cleared
        tick(0, 1, 8'hc4, 16'h0002, 0);
        for (int b = 0; b < 4; b++) begin
            tick(0, 1, 8'hc8, 16'h7e00 ^ (16'h4000 >> b), 0);
            tick(0, 0, 0, 0, 9'h100 >> b);
            tick(1, 0, 8'hc8, 0, 0);
        end
        // Both counters through half-full to saturation, carrier toggled
        tick(0, 1, 8'hc8, 0, 0);
        repeat (300) begin
            tick(0, 0, 0, 0, 9'h01c);
            tick(0, 0, 0, 0, 9'h006);
        end
        foreach (addrs[k]) tick(1, 0, addrs[k], 0, 0);
        // Random traffic, mapped and unmapped, with sparse events
        repeat (6000) begin
            r = $random(seed);
            tick(r[1:0] == 0, r[1:0] == 1, addrs[r[4:2] % 6], 16'($random(seed)), 9'($random(seed) & $random(seed)));
        end
        tick(0, 0, 0, 0, 0);
        wrap_up();
    end
endmodule : tb
